// >>> rtl/pslam_pkg.sv
// Package: constants and types for the panel setup and limit alarm block
package pslam_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CONV_PER_SEC    = 7;                        // Conversions each second
  localparam int unsigned CONV_CYC        = CLK_HZ / CONV_PER_SEC;    // Longest period rounds down
  localparam int unsigned DEB_MS          = 10;                       // Key debounce time
  localparam int unsigned DEB_CYC         = CLK_HZ / 1000 * DEB_MS;
  localparam int unsigned TEST_MS         = 1000;                     // Display test time
  localparam int unsigned TEST_CYC        = CLK_HZ / 1000 * TEST_MS;
  localparam int unsigned BRIEF_MS        = 2000;                     // Brief parameter view
  localparam int unsigned BRIEF_CYC       = CLK_HZ / 1000 * BRIEF_MS;
  localparam int unsigned RST_HOLD_MS     = 1000;                     // Reset key hold to leave setup
  localparam int unsigned RST_HOLD_CYC    = CLK_HZ / 1000 * RST_HOLD_MS;

  // ****************************************
  // Numbers
  // ****************************************
  localparam int unsigned NKEYS           = 8;
  localparam int unsigned NALARM          = 6;
  localparam logic [15:0] SCALE_MIN       = 16'h0001;
  localparam logic [15:0] SCALE_MAX       = 16'h7530;   // 30000
  localparam logic [15:0] OFFSET_MAX      = 16'h7530;   // 30000
  localparam logic [15:0] PASS_D0         = 16'h0003;
  localparam logic [15:0] PASS_D1         = 16'h0002;
  localparam logic [15:0] PASS_D2         = 16'h0005;
  localparam logic [15:0] PASS_D3         = 16'h0004;
  localparam logic [1:0]  MAX_TRIES       = 2'h3;
  localparam logic [1:0]  NGROUPS_M1      = 2'h2;        // Three groups
  localparam logic [15:0] TEST_PATTERN    = 16'h8888;

  // Key indices
  localparam int unsigned K_SETUP = 0;
  localparam int unsigned K_RESET = 1;
  localparam int unsigned K_DIG   = 2;
  localparam int unsigned K_LIMIT = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PSLAM_MSG_VALUE, PSLAM_MSG_TEST, PSLAM_MSG_WARN, PSLAM_MSG_PASS,
    PSLAM_MSG_GROUP, PSLAM_MSG_SAVING, PSLAM_MSG_PARAM, PSLAM_MSG_HOLD
  } pslam_msg_t;

  typedef struct packed {
    pslam_msg_t  msg;
    logic [15:0] value;
  } pslam_disp_t;

  typedef struct packed {
    logic [15:0] limit;
    logic [15:0] level;      // Process, rate, deviation or timer value
    logic        latching;
  } pslam_alarm_cfg_t;

endpackage : pslam_pkg

// >>> rtl/pslam_top.sv
// Module: front panel command interpreter with limit alarm relays
`timescale 1ns/1ps

// Notes on behaviour
// - Low hold pin enters hold function
// - Readings refresh seven times per second
// - Over or under range shows warning outside test and setup
// - Power-up shows 8888 display test briefly
// - Held key shows parameter, tap shows briefly
// - Invalid key or sequence shows warning
// - Six alarms, limit 3 rate, 4 deviation
// - Non-latching releases below limit minus deadband
// - Latching stays on until manual reset
// - Two setup presses give passcode prompt
// - Four-digit passcode 3254 only
// - Wrong passcode digit shows warning
// - Three failed attempts leave setup
// - Held reset key saves and exits
// - Scale clamped to 1 through 30000
// - Offset clamped to 0 through 30000
// - Tare clamped to programmed scale
// - Digit steps groups, setup selects
module pslam_top
  import pslam_pkg::*;
#(
  parameter int unsigned DEB_CYCLES   = DEB_CYC,
  parameter int unsigned TEST_CYCLES  = TEST_CYC,
  parameter int unsigned BRIEF_CYCLES = BRIEF_CYC,
  parameter int unsigned HOLD_CYCLES  = RST_HOLD_CYC,
  parameter int unsigned CONV_CYCLES  = CONV_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic [NKEYS-1:0]           key_raw,
  input  wire logic [3:0]                 key_digit [NKEYS],
  input  wire logic                       hold_n_pin,
  input  wire logic                       range_err,
  input  wire logic [15:0]                meas_value,
  input  wire logic [15:0]                scale_in,
  input  wire logic [15:0]                offset_in,
  input  wire logic [15:0]                tare_in,
  input  wire logic                       param_we,
  input  wire logic [15:0]                param_value,
  input  wire pslam_alarm_cfg_t [NALARM-1:0] alarm_cfg,
  input  wire logic [15:0]                deadband,
  input  wire logic                       nv_done,
  output pslam_disp_t                     disp_q,
  output logic [NALARM-1:0]               relay_q,
  output logic                            hold_q,
  output logic                            setup_q,
  output logic [1:0]                      group_q,
  output logic                            group_sel_q,
  output logic                            nv_write_q,
  output logic                            conv_tick_q,
  output logic [15:0]                     scale_q,
  output logic [15:0]                     offset_q,
  output logic [15:0]                     tare_q
);

  // ****************************************
  // Pin synchronisers (three stages)
  // ****************************************
  logic [NKEYS:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {~hold_n_pin, key_raw};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ****************************************
  // Key debounce: a level counts once stable for DEB_CYCLES
  // ****************************************
  logic [NKEYS-1:0] key_lvl_q, key_lvl_d, key_evt_q, key_evt_d;
  logic [31:0]      deb_cnt_q [NKEYS], deb_cnt_d [NKEYS];
  logic             hold_d;
  always_comb begin
    for (int i = 0; i < NKEYS; i++) begin
      key_lvl_d[i] = key_lvl_q[i];
      key_evt_d[i] = 1'b0;
      deb_cnt_d[i] = 32'h0;
      if ((s2_q[i] == s3_q[i]) && (s3_q[i] != key_lvl_q[i])) begin
        deb_cnt_d[i] = deb_cnt_q[i] + 32'h1;
        if (deb_cnt_q[i] >= DEB_CYCLES - 1) begin
          key_lvl_d[i] = s3_q[i];
          key_evt_d[i] = s3_q[i];
          deb_cnt_d[i] = 32'h0;
        end
      end
    end
    hold_d = (s2_q[NKEYS] == s3_q[NKEYS]) ? s3_q[NKEYS] : hold_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_lvl_q <= '0;
      key_evt_q <= '0;
      hold_q    <= 1'b0;
      for (int i = 0; i < NKEYS; i++) deb_cnt_q[i] <= 32'h0;
    end else begin
      key_lvl_q <= key_lvl_d;
      key_evt_q <= key_evt_d;
      hold_q    <= hold_d;
      deb_cnt_q <= deb_cnt_d;
    end
  end

  // ****************************************
  // Panel state machine
  // ****************************************
  typedef enum logic [2:0] {ST_TEST, ST_RUN, ST_ARMED, ST_PASS, ST_GROUP, ST_EDIT, ST_SAVE} pslam_state_t;
  pslam_state_t state_q, state_d;
  logic [31:0]  tmr_q, tmr_d, hold_cnt_q, hold_cnt_d, conv_q, conv_d;
  logic [1:0]   digit_idx_q, digit_idx_d, tries_q, tries_d, group_d;
  logic         bad_q, bad_d, warn_q, warn_d, setup_d, group_sel_d, nv_write_d, conv_tick_d, brief_q, brief_d;
  logic [15:0]  pass_exp, disp_val_q, disp_val_d, scale_d, offset_d, tare_d;
  logic [3:0]   pressed_digit;
  logic         any_key, digit_key;
  pslam_msg_t   msg_d;

  always_comb begin
    any_key = |key_evt_q;
    digit_key = 1'b0;
    pressed_digit = 4'h0;
    for (int i = NKEYS - 1; i >= 0; i--) begin
      if (key_evt_q[i]) begin
        digit_key = 1'b1;
        pressed_digit = key_digit[i];
      end
    end
    case (digit_idx_q)
      2'h0:    pass_exp = PASS_D0;
      2'h1:    pass_exp = PASS_D1;
      2'h2:    pass_exp = PASS_D2;
      default: pass_exp = PASS_D3;
    endcase
  end

  // Next state and outputs of the panel
  always_comb begin
    state_d     = state_q;
    tmr_d       = (tmr_q != 32'h0) ? tmr_q - 32'h1 : 32'h0;
    hold_cnt_d  = key_lvl_q[K_RESET] ? hold_cnt_q + 32'h1 : 32'h0;
    conv_d      = (conv_q >= CONV_CYCLES - 1) ? 32'h0 : conv_q + 32'h1;
    conv_tick_d = (conv_q >= CONV_CYCLES - 1);
    digit_idx_d = digit_idx_q;
    tries_d     = tries_q;
    bad_d       = bad_q;
    warn_d      = 1'b0;
    brief_d     = brief_q;
    group_d     = group_q;
    group_sel_d = 1'b0;
    nv_write_d  = nv_write_q;
    setup_d     = setup_q;
    scale_d     = scale_q;
    offset_d    = offset_q;
    tare_d      = tare_q;
    disp_val_d  = conv_tick_q ? meas_value : disp_val_q;
    if (hold_q) disp_val_d = disp_val_q;                   // Reading frozen on hold
    case (state_q)
      ST_TEST: if (tmr_q == 32'h0) state_d = ST_RUN;
      ST_RUN, ST_ARMED: begin
        if (key_lvl_q[K_LIMIT]) begin
          brief_d = 1'b1;
          tmr_d   = BRIEF_CYCLES;
        end else if (tmr_q == 32'h0) begin
          brief_d = 1'b0;
        end
        if (key_evt_q[K_SETUP]) begin
          if (state_q == ST_ARMED) begin
            state_d     = ST_PASS;
            setup_d     = 1'b1;
            digit_idx_d = 2'h0;
            tries_d     = 2'h0;
            bad_d       = 1'b0;
            brief_d     = 1'b0;
          end else begin
            state_d = ST_ARMED;
          end
        end else if (any_key && !key_evt_q[K_LIMIT]) begin
          warn_d  = 1'b1;
          state_d = ST_RUN;
        end
      end
      ST_PASS: begin
        if (digit_key && !key_evt_q[K_RESET]) begin      // Reset key only counts its hold
          if (pressed_digit != pass_exp[3:0]) begin
            warn_d = 1'b1;
            bad_d  = 1'b1;
          end
          digit_idx_d = digit_idx_q + 2'h1;
          if (digit_idx_q == 2'h3) begin
            digit_idx_d = 2'h0;
            bad_d       = 1'b0;
            if (!bad_q && pressed_digit == pass_exp[3:0]) begin
              state_d = ST_GROUP;
              group_d = 2'h0;
            end else if (tries_q == MAX_TRIES - 2'h1) begin
              state_d = ST_RUN;
              setup_d = 1'b0;
            end else begin
              tries_d = tries_q + 2'h1;
            end
          end
        end
      end
      ST_GROUP: begin
        if (key_evt_q[K_DIG]) begin
          group_d = (group_q == NGROUPS_M1) ? 2'h0 : group_q + 2'h1;
        end else if (key_evt_q[K_SETUP]) begin
          group_sel_d = 1'b1;
          state_d     = ST_EDIT;
        end else if (any_key && !key_evt_q[K_RESET]) begin
          warn_d = 1'b1;
        end
      end
      ST_EDIT: begin
        if (param_we) begin
          scale_d = (param_value < SCALE_MIN) ? SCALE_MIN :
                    (param_value > SCALE_MAX) ? SCALE_MAX : param_value;
        end
        offset_d = (offset_in > OFFSET_MAX) ? OFFSET_MAX : offset_in;
        tare_d   = (tare_in > scale_d) ? scale_d : tare_in;                // New scale, no stale cycle
        if (key_evt_q[K_SETUP]) state_d = ST_GROUP;
      end
      ST_SAVE: begin
        nv_write_d = 1'b1;
        if (nv_done) begin
          nv_write_d = 1'b0;
          setup_d    = 1'b0;
          state_d    = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
    // Held reset key leaves setup from any setup state
    if (setup_q && state_q != ST_SAVE && hold_cnt_q >= HOLD_CYCLES - 1) begin
      state_d = ST_SAVE;
    end
    // Scale from the input pins is also kept in range
    if (state_q != ST_EDIT) begin
      scale_d  = (scale_in < SCALE_MIN) ? SCALE_MIN :
                 (scale_in > SCALE_MAX) ? SCALE_MAX : scale_in;
      offset_d = (offset_in > OFFSET_MAX) ? OFFSET_MAX : offset_in;
      tare_d   = (tare_in > scale_d) ? scale_d : tare_in;
    end
    // Display selection, warning has priority over reading
    case (state_d)
      ST_TEST:  msg_d = PSLAM_MSG_TEST;
      ST_PASS:  msg_d = PSLAM_MSG_PASS;
      ST_GROUP: msg_d = PSLAM_MSG_GROUP;
      ST_EDIT:  msg_d = PSLAM_MSG_PARAM;
      ST_SAVE:  msg_d = PSLAM_MSG_SAVING;
      default:  msg_d = brief_d ? PSLAM_MSG_PARAM : (hold_q ? PSLAM_MSG_HOLD : PSLAM_MSG_VALUE);
    endcase
    if (warn_d || warn_q) msg_d = PSLAM_MSG_WARN;
    if (range_err && (state_d == ST_RUN || state_d == ST_ARMED)) msg_d = PSLAM_MSG_WARN;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q      <= ST_TEST;
      tmr_q        <= TEST_CYCLES;
      hold_cnt_q   <= 32'h0;
      conv_q       <= 32'h0;
      conv_tick_q  <= 1'b0;
      digit_idx_q  <= 2'h0;
      tries_q      <= 2'h0;
      bad_q        <= 1'b0;
      warn_q       <= 1'b0;
      brief_q      <= 1'b0;
      group_q      <= 2'h0;
      group_sel_q  <= 1'b0;
      nv_write_q   <= 1'b0;
      setup_q      <= 1'b0;
      scale_q      <= SCALE_MIN;
      offset_q     <= 16'h0;
      tare_q       <= 16'h0;
      disp_val_q   <= 16'h0;
      disp_q       <= '{msg: PSLAM_MSG_TEST, value: TEST_PATTERN};
    end else begin
      state_q      <= state_d;
      tmr_q        <= tmr_d;
      hold_cnt_q   <= hold_cnt_d;
      conv_q       <= conv_d;
      conv_tick_q  <= conv_tick_d;
      digit_idx_q  <= digit_idx_d;
      tries_q      <= tries_d;
      bad_q        <= bad_d;
      warn_q       <= warn_d;
      brief_q      <= brief_d;
      group_q      <= group_d;
      group_sel_q  <= group_sel_d;
      nv_write_q   <= nv_write_d;
      setup_q      <= setup_d;
      scale_q      <= scale_d;
      offset_q     <= offset_d;
      tare_q       <= tare_d;
      disp_val_q   <= disp_val_d;
      disp_q       <= '{msg: msg_d, value: (msg_d == PSLAM_MSG_TEST) ? TEST_PATTERN : disp_val_d};
    end
  end

  // ****************************************
  // Limit alarms
  // ****************************************
  logic [NALARM-1:0] relay_d;
  logic [16:0]       rel_lvl;
  always_comb begin
    rel_lvl = 17'h0;
    for (int a = 0; a < NALARM; a++) begin
      relay_d[a] = relay_q[a];
      rel_lvl = (alarm_cfg[a].limit > deadband) ? {1'b0, alarm_cfg[a].limit - deadband} : 17'h0;
      if (alarm_cfg[a].level >= alarm_cfg[a].limit) begin  // Level is process, rate or deviation
        relay_d[a] = 1'b1;
      end else if (!alarm_cfg[a].latching && {1'b0, alarm_cfg[a].level} < rel_lvl) begin
        relay_d[a] = 1'b0;
      end
      if (alarm_cfg[a].latching && key_evt_q[K_RESET] && !setup_q &&
          alarm_cfg[a].level < alarm_cfg[a].limit) begin
        relay_d[a] = 1'b0;                                 // Manual reset only
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) relay_q <= '0;
    else         relay_q <= relay_d;
  end

endmodule : pslam_top

// >>> tb/pslam_sva.sv
// Checker: port-level assertions for the panel setup and limit alarm block
`timescale 1ns/1ps
module pslam_sva
  import pslam_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  input wire logic                          clk,
  input wire logic                          sys_rst,
  input wire logic [NKEYS-1:0]              key_raw,
  input wire logic                          hold_n_pin,
  input wire logic                          range_err,
  input wire pslam_alarm_cfg_t [NALARM-1:0] alarm_cfg,
  input wire logic [15:0]                   deadband,
  input wire pslam_disp_t                   disp_q,
  input wire logic [NALARM-1:0]             relay_q,
  input wire logic                          hold_q,
  input wire logic                          setup_q,
  input wire logic                          group_sel_q,
  input wire logic                          nv_write_q,
  input wire logic                          conv_tick_q,
  input wire logic [15:0]                   scale_q,
  input wire logic [15:0]                   offset_q,
  input wire logic [15:0]                   tare_q
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  int unsigned gap_q, gap_d;
  logic        seen_q, seen_d;

  // Cycles since last tick; first tick has no reference
  always_comb begin
    gap_d  = conv_tick_q ? 1 : gap_q + 1;
    seen_d = seen_q | conv_tick_q;
  end

  // Counter registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_q  <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
    end
  end

  a_test_after_reset: assert property ($fell(sys_rst) |-> disp_q.msg == PSLAM_MSG_TEST && disp_q.value == TEST_PATTERN)
    else $error("No display test after reset");
  a_hold_follows_pin: assert property ((!hold_n_pin) [*8] |-> hold_q)
    else $error("Hold not entered");
  a_range_warn_shown: assert property ((range_err && !setup_q && disp_q.msg != PSLAM_MSG_TEST) [*3] |->
    disp_q.msg == PSLAM_MSG_WARN)
    else $error("Range warning missing");
  a_conv_tick_gap: assert property (conv_tick_q && seen_q |-> gap_q == CONV_CYCLES)
    else $error("Conversion period wrong");
  a_group_sel_pulse: assert property (group_sel_q |=> !group_sel_q)
    else $error("Group select longer than one cycle");
  a_scale_in_range: assert property (scale_q >= SCALE_MIN && scale_q <= SCALE_MAX)
    else $error("Scale out of range");
  a_offset_in_range: assert property (offset_q <= OFFSET_MAX)
    else $error("Offset out of range");
  a_tare_below_scale: assert property (tare_q <= scale_q)
    else $error("Tare above scale");
  a_save_in_setup: assert property (nv_write_q |-> setup_q)
    else $error("Save outside setup");

  // Per-alarm relay behaviour
  for (genvar i = 0; i < NALARM; i++) begin : g_alarm
    a_relay_sets: assert property (alarm_cfg[i].level >= alarm_cfg[i].limit |=> relay_q[i])
      else $error("Relay not energized at limit");
    a_relay_releases: assert property (relay_q[i] && !alarm_cfg[i].latching &&
      ({1'b0, alarm_cfg[i].level} + {1'b0, deadband} < {1'b0, alarm_cfg[i].limit}) |-> ##[1:2] !relay_q[i])
      else $error("Relay did not release");
    a_latch_keeps: assert property ((relay_q[i] && alarm_cfg[i].latching && !key_raw[K_RESET]) [*8] |=> relay_q[i])
      else $error("Latched relay dropped");
  end

  c_save: cover property ($rose(nv_write_q));
  c_group_sel: cover property (group_sel_q);
  c_hold: cover property ($rose(hold_q));
endmodule : pslam_sva

bind pslam_top pslam_sva #(.CONV_CYCLES(CONV_CYCLES)) u_pslam_sva (
  .clk(clk), .sys_rst(sys_rst), .key_raw(key_raw), .hold_n_pin(hold_n_pin), .range_err(range_err),
  .alarm_cfg(alarm_cfg), .deadband(deadband), .disp_q(disp_q), .relay_q(relay_q), .hold_q(hold_q),
  .setup_q(setup_q), .group_sel_q(group_sel_q), .nv_write_q(nv_write_q), .conv_tick_q(conv_tick_q),
  .scale_q(scale_q), .offset_q(offset_q), .tare_q(tare_q));

// >>> tb/pslam_nvm_model.sv
// Partner: nonvolatile memory that acknowledges a save after a delay
`timescale 1ns/1ps
module pslam_nvm_model #(
  parameter int unsigned DELAY = 6
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic nv_write_q,
  output logic      nv_done
);
  int unsigned cnt_q;

  // One-cycle done pulse; write time is not instant, like a real part
  always_ff @(posedge clk) begin
    if (sys_rst || !nv_write_q) begin
      cnt_q   <= 0;
      nv_done <= 1'b0;
    end else begin
      cnt_q   <= cnt_q + 1;
      nv_done <= (cnt_q == DELAY);
    end
  end
endmodule : pslam_nvm_model

// >>> tb/pslam_top_bench.sv
// Testbench: keypad sequences, alarms and display checks for the block
`timescale 1ns/1ps
module pslam_top_bench;
  import pslam_pkg::*;
  localparam int unsigned TC = 20;
  localparam int unsigned CC = 50;

  logic                          clk = 1'b0, sys_rst = 1'b1, hold_n_pin = 1'b1, range_err = 1'b0;
  logic [NKEYS-1:0]              key_raw = '0;
  logic [3:0]                    key_digit [NKEYS];
  logic [15:0]                   meas_value = 16'h0042, deadband = 16'h0010, n_tick;
  logic [15:0]                   scale_in = 16'h1388, offset_in = 16'hffff, tare_in = 16'hffff;
  logic                          param_we = 1'b0, nv_done;
  logic [15:0]                   param_value = 16'h1388;
  pslam_alarm_cfg_t [NALARM-1:0] alarm_cfg;
  pslam_disp_t                   disp_q;
  logic [NALARM-1:0]             relay_q;
  logic                          hold_q, setup_q, group_sel_q, nv_write_q, conv_tick_q;
  logic [1:0]                    group_q;
  logic [15:0]                   scale_q, offset_q, tare_q;
  int                            mismatches = 0, tests_run = 0;

  pslam_top #(.DEB_CYCLES(4), .TEST_CYCLES(TC), .BRIEF_CYCLES(20), .HOLD_CYCLES(10), .CONV_CYCLES(CC)) u_pslam_top (
    .clk(clk), .sys_rst(sys_rst), .key_raw(key_raw), .key_digit(key_digit), .hold_n_pin(hold_n_pin),
    .range_err(range_err), .meas_value(meas_value), .scale_in(scale_in), .offset_in(offset_in),
    .tare_in(tare_in), .param_we(param_we), .param_value(param_value), .alarm_cfg(alarm_cfg),
    .deadband(deadband), .nv_done(nv_done), .disp_q(disp_q), .relay_q(relay_q), .hold_q(hold_q),
    .setup_q(setup_q), .group_q(group_q), .group_sel_q(group_sel_q), .nv_write_q(nv_write_q),
    .conv_tick_q(conv_tick_q), .scale_q(scale_q), .offset_q(offset_q), .tare_q(tare_q));
  pslam_nvm_model u_pslam_nvm_model (.clk(clk), .sys_rst(sys_rst), .nv_write_q(nv_write_q), .nv_done(nv_done));

  // ****************************************
  // Tasks
  // ****************************************
  always #10 clk = ~clk;

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_word

  // Held for n cycles, then released long enough to debounce
  task automatic press(input int k, input int n);
    key_raw[k] = 1'b1;
    repeat (n) @(negedge clk);
    key_raw[k] = 1'b0;
    repeat (12) @(negedge clk);
  endtask : press

  // Short messages stand two cycles, so poll every cycle
  task automatic see_msg(input pslam_msg_t e, input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (disp_q.msg === e) hit = 1'b1;
    end
    check_word({15'h0, hit}, 16'h0001);
  endtask : see_msg

  task automatic give_verdict;
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Later attempts stay in passcode entry, so only the first one arms setup
  task automatic enter_code(input bit arm, input int d0, input int d1, input int d2, input int d3);
    if (arm) begin
      press(K_SETUP, 8);
      press(K_SETUP, 8);
      check_word({13'h0, disp_q.msg}, {13'h0, PSLAM_MSG_PASS});
    end
    press(d0, 8);
    press(d1, 8);
    press(d2, 8);
    press(d3, 8);
  endtask : enter_code

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    for (int k = 0; k < NKEYS; k++) key_digit[k] = k[3:0];
    for (int i = 0; i < NALARM; i++) alarm_cfg[i] = '{16'h0100, 16'h0000, i == 1};
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check_word(disp_q.value, TEST_PATTERN);
    repeat (TC + 4) @(negedge clk);
    check_word({13'h0, disp_q.msg}, {13'h0, PSLAM_MSG_VALUE});
    fork press(K_DIG, 10); see_msg(PSLAM_MSG_WARN, 20); join
    fork press(K_LIMIT, 8); see_msg(PSLAM_MSG_PARAM, 14); join
    repeat (30) @(negedge clk);
    check_word({13'h0, disp_q.msg}, {13'h0, PSLAM_MSG_VALUE});
    key_raw[K_LIMIT] = 1'b1;
    repeat (60) @(negedge clk);
    check_word({13'h0, disp_q.msg}, {13'h0, PSLAM_MSG_PARAM});
    key_raw[K_LIMIT] = 1'b0;
    repeat (50) @(negedge clk);
    for (int a = 0; a < 3; a++) begin
      fork
        enter_code(a == 0, 3, 2, 5, 7);
        begin
          repeat ((a == 0) ? 100 : 60) @(negedge clk);
          see_msg(PSLAM_MSG_WARN, 20);
        end
      join
      check_word({15'h0, setup_q}, {15'h0, a < 2});
    end
    repeat (8) @(negedge clk);
    check_word({15'h0, setup_q}, 16'h0000);
    enter_code(1'b1, 3, 2, 5, 4);
    check_word({12'h0, 1'b0, disp_q.msg}, {13'h0, PSLAM_MSG_GROUP});
    for (int g = 1; g < 4; g++) begin
      press(K_DIG, 8);
      check_word({14'h0, group_q}, 16'(g % 3));
    end
    press(K_SETUP, 8);
    param_we = 1'b1;
    @(negedge clk);
    param_we = 1'b0;
    key_raw[K_RESET] = 1'b1;
    see_msg(PSLAM_MSG_SAVING, 40);
    key_raw[K_RESET] = 1'b0;
    repeat (20) @(negedge clk);
    check_word({15'h0, setup_q}, 16'h0000);
    check_word(scale_q, 16'h1388);
    check_word(offset_q, OFFSET_MAX);
    check_word(tare_q, 16'h1388);
    hold_n_pin = 1'b0;
    repeat (10) @(negedge clk);
    check_word({15'h0, hold_q}, 16'h0001);
    hold_n_pin = 1'b1;
    range_err = 1'b1;
    repeat (20) @(negedge clk);
    check_word({13'h0, disp_q.msg}, {13'h0, PSLAM_MSG_WARN});
    range_err = 1'b0;
    n_tick = '0;
    repeat (CC * 10) begin
      @(negedge clk);
      n_tick = n_tick + {15'h0, conv_tick_q};
    end
    check_word(n_tick, 16'h000a);
    check_word(disp_q.value, 16'h0042);
    for (int i = 0; i < NALARM; i++) alarm_cfg[i].level = 16'h0100;
    repeat (3) @(negedge clk);
    check_word({10'h0, relay_q}, 16'h003f);
    for (int i = 0; i < NALARM; i++) alarm_cfg[i].level = 16'h00f8;
    repeat (3) @(negedge clk);
    check_word({10'h0, relay_q}, 16'h003f);
    for (int i = 0; i < NALARM; i++) alarm_cfg[i].level = 16'h00e0;
    repeat (20) @(negedge clk);
    check_word({10'h0, relay_q}, 16'h0002);
    press(K_RESET, 8);
    check_word({10'h0, relay_q}, 16'h0000);
    give_verdict();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule : pslam_top_bench
